// *** rtl/scbs_top.sv ***
// Purpose: control and data path of a serial configuration bitstream source
// Assumes: pins arrive asynchronous to sys_clk; memory loaded over prog port
// Notes:   the serial clock is made here by dividing sys_clk
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - enable line low clears counter, floats data
// - select high after reset: counter halted, float
// - select low after release: count and drive
// - later enable low clears again, select ignored
// - mode sampled when enable line rises
// - float data after last bit, cascade low
// - enable line is open-drain both ways
// - enable and select gate buffer, counter, oscillator
// - reconfigure instruction pulls request output low
// - release request when instruction state ends
// - shift bits serially, drive serial clock out
// - float behaviour same at any chain position
module scbs_top #(
  parameter int WORD_W     = scbs_pkg::WORD_W,
  parameter int MEM_WORDS  = scbs_pkg::MEM_WORDS,
  parameter int FIFO_DEPTH = scbs_pkg::FIFO_DEPTH,
  parameter int STREAM_BITS = scbs_pkg::MEM_WORDS * scbs_pkg::WORD_W
) (
  input  wire logic                           sys_clk,
  input  wire logic                           rst,
  // memory load port
  input  wire logic                           prog_we,
  input  wire logic [$clog2(MEM_WORDS)-1:0]   prog_addr,
  input  wire logic [WORD_W-1:0]              prog_data,
  // open-drain enable / counter reset line
  input  wire logic                           oe_in,
  output logic                                oe_out,
  output logic                                oe_oe_n,
  // chip select from the target, active low
  input  wire logic                           sel_n_in,
  // mode straps
  input  wire logic [scbs_pkg::MODE_W-1:0]    mode_in,
  // serial link to the target
  output logic                                dclk_out,
  output logic                                target_serial_in,
  output logic                                target_serial_in_oe_n,
  output logic                                cascade_select_out,
  // reconfigure request from the test access logic
  input  wire logic                           reconf_instr,
  output logic                                init_conf_out,
  output logic                                init_conf_oe_n,
  // status
  output logic [scbs_pkg::MODE_W-1:0]         active_mode
);

  localparam int AW  = $clog2(MEM_WORDS);
  localparam int RAW = $clog2(MEM_WORDS + 1);
  localparam int BW  = $clog2(STREAM_BITS + 1);
  localparam int SW  = $clog2(WORD_W + 1);
  localparam int DW  = $clog2(scbs_pkg::DCLK_HALF + 1);
  localparam int PW  = $clog2(scbs_pkg::POR_CYCLES + 1);
  localparam logic [RAW-1:0] WORDS_END = RAW'(MEM_WORDS);
  localparam logic [BW-1:0]  BITS_END  = BW'(STREAM_BITS);
  localparam logic [SW-1:0]  WORD_BITS = SW'(WORD_W);
  localparam logic [DW-1:0]  HALF_LAST = DW'(scbs_pkg::DCLK_HALF - 1);
  localparam logic [PW-1:0]  POR_END   = PW'(scbs_pkg::POR_CYCLES);

  //////////////////////////////////////////////////////////////////////////
  // input synchronisers

  scbs_pkg::scbs_pins_t pins_raw;
  scbs_pkg::scbs_pins_t pins_meta_r;
  scbs_pkg::scbs_pins_t pins_r;
  logic                 oe_prev_r;
  logic                 oe_rise;

  assign pins_raw = '{oe: oe_in, sel_n: sel_n_in,
                      reconf: reconf_instr, mode: mode_in};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pins_meta_r <= scbs_pkg::PINS_RESET;
      pins_r      <= scbs_pkg::PINS_RESET;
    end else begin
      pins_meta_r <= pins_raw;
      pins_r      <= pins_meta_r;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      oe_prev_r <= 1'b0;
    end else begin
      oe_prev_r <= pins_r.oe;
    end
  end

  assign oe_rise = pins_r.oe && !oe_prev_r;

  //////////////////////////////////////////////////////////////////////////
  // power-up hold of the shared enable line

  logic [PW-1:0] por_cnt_r;
  logic          por_busy;

  assign por_busy = (por_cnt_r != POR_END);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      por_cnt_r <= '0;
    end else if (por_busy) begin
      por_cnt_r <= por_cnt_r + 1'b1;
    end
  end

  // only ever pull low or let go; pull-up lives outside
  assign oe_out  = 1'b0;
  assign oe_oe_n = !por_busy;

  //////////////////////////////////////////////////////////////////////////
  // control state

  scbs_pkg::scbs_state_t       state_r;
  logic [scbs_pkg::MODE_W-1:0] mode_r;
  logic [BW-1:0]               bit_addr_r;
  logic                        active;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= scbs_pkg::ST_CLEAR;
    end else if (!pins_r.oe) begin
      state_r <= scbs_pkg::ST_CLEAR;
    end else begin
      case (state_r)
        scbs_pkg::ST_CLEAR: begin
          state_r <= scbs_pkg::ST_ARMED;
        end
        scbs_pkg::ST_ARMED: begin
          if (bit_addr_r == BITS_END) begin
            state_r <= scbs_pkg::ST_DONE;
          end
        end
        scbs_pkg::ST_DONE: begin
          state_r <= scbs_pkg::ST_DONE;
        end
        default: begin
          state_r <= scbs_pkg::ST_CLEAR;
        end
      endcase
    end
  end

  // straps are read once per release so a mid-stream change is harmless
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_r <= scbs_pkg::MODE_RESET;
    end else if (oe_rise) begin
      mode_r <= pins_r.mode;
    end
  end

  assign active_mode = mode_r;

  // select high halts in place; counter keeps its position
  // a low line already seen stops new clock edges before the state clears
  assign active = (state_r == scbs_pkg::ST_ARMED) && pins_r.oe
                  && !pins_r.sel_n
                  && (bit_addr_r != BITS_END);

  //////////////////////////////////////////////////////////////////////////
  // bitstream memory and prefetch into the FIFO

  logic [WORD_W-1:0] mem_r [MEM_WORDS];
  logic [RAW-1:0]    rd_addr_r;
  logic              fetch_valid;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [WORD_W-1:0] fifo_out_data;
  logic              flush;

  always_ff @(posedge sys_clk) begin
    if (prog_we) begin
      mem_r[prog_addr] <= prog_data;
    end
  end

  assign flush       = (state_r == scbs_pkg::ST_CLEAR);
  assign fetch_valid = (state_r == scbs_pkg::ST_ARMED)
                       && (rd_addr_r != WORDS_END);

  // prefetch runs ahead while select is high so the first bit is ready
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_addr_r <= '0;
    end else if (flush) begin
      rd_addr_r <= '0;
    end else if (fetch_valid && fifo_in_ready) begin
      rd_addr_r <= rd_addr_r + 1'b1;
    end
  end

  scbs_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .flush     (flush),
    .in_valid  (fetch_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (mem_r[rd_addr_r[AW-1:0]]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  //////////////////////////////////////////////////////////////////////////
  // serial clock divider, starts a high phase only while enabled and a bit is ready

  logic [DW-1:0] div_cnt_r;
  logic          dclk_r;
  logic          sh_valid_r;
  logic          osc_run;
  logic          tick;
  logic          bit_open;

  // a started high phase always runs to its falling edge: cutting it
  // short would let the target sample the same bit twice on resume
  assign osc_run  = (active && sh_valid_r) || dclk_r;
  assign bit_open = dclk_r && (state_r == scbs_pkg::ST_ARMED);
  // tick marks the falling edge: data changes while dclk is low
  assign tick    = osc_run && dclk_r && (div_cnt_r == HALF_LAST);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_cnt_r <= '0;
      dclk_r    <= 1'b0;
    end else if (!osc_run) begin
      div_cnt_r <= '0;
      dclk_r    <= 1'b0;
    end else begin
      if (div_cnt_r == HALF_LAST) begin
        div_cnt_r <= '0;
        dclk_r    <= !dclk_r;
      end else begin
        div_cnt_r <= div_cnt_r + 1'b1;
      end
    end
  end

  assign dclk_out = dclk_r;

  //////////////////////////////////////////////////////////////////////////
  // shifter and bit address counter

  logic [WORD_W-1:0] sh_r;
  logic [SW-1:0]     sh_left_r;
  logic              last_in_word;
  logic              lsb_first;

  assign last_in_word   = (sh_left_r == SW'(1));
  assign lsb_first      = mode_r[scbs_pkg::MODE_LSB_FIRST_BIT];
  // an empty FIFO stalls the serial clock rather than sending junk
  assign fifo_out_ready = active && (!sh_valid_r || (tick && last_in_word));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sh_r       <= '0;
      sh_left_r  <= '0;
      sh_valid_r <= 1'b0;
    end else if (flush) begin
      sh_r       <= '0;
      sh_left_r  <= '0;
      sh_valid_r <= 1'b0;
    end else if (fifo_out_ready && fifo_out_valid) begin
      sh_r       <= fifo_out_data;
      sh_left_r  <= WORD_BITS;
      sh_valid_r <= 1'b1;
    end else if (tick) begin
      if (last_in_word) begin
        sh_valid_r <= 1'b0;
        sh_left_r  <= '0;
      end else begin
        sh_r      <= lsb_first ? (sh_r >> 1) : (sh_r << 1);
        sh_left_r <= sh_left_r - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bit_addr_r <= '0;
    end else if (flush) begin
      bit_addr_r <= '0;
    end else if (tick) begin
      bit_addr_r <= bit_addr_r + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin drivers

  // float rule ignores chain position: done, halted or cleared all float
  // data keeps standing through a high phase that outlives select
  assign target_serial_in_oe_n = !(active || bit_open);
  assign target_serial_in      = lsb_first ? sh_r[0] : sh_r[WORD_W-1];
  assign cascade_select_out    = (state_r != scbs_pkg::ST_DONE);

  // request is only ever pulled low, then released to start the target
  assign init_conf_out  = 1'b0;
  assign init_conf_oe_n = !pins_r.reconf;

endmodule : scbs_top
`default_nettype wire

// *** rtl/scbs_pkg.sv ***
// Purpose: shared constants and types of the serial bitstream source
// Assumes: sys_clk at 50 MHz
// Notes:   all timing counts derive from the times below
package scbs_pkg;

  localparam int SYS_PERIOD_NS  = 20;
  localparam int LINK_PERIOD_NS = 160;
  // half period of the serial clock in sys_clk cycles, at least one
  localparam int DCLK_HALF = (LINK_PERIOD_NS / SYS_PERIOD_NS / 2) < 1 ? 1 :
                             (LINK_PERIOD_NS / SYS_PERIOD_NS / 2);
  // internal pull-down of the open-drain enable line after power-up
  localparam int POR_TIME_NS = 1000;
  localparam int POR_CYCLES  = (POR_TIME_NS + SYS_PERIOD_NS - 1)
                               / SYS_PERIOD_NS;

  localparam int WORD_W     = 8;
  localparam int MEM_WORDS  = 64;
  localparam int FIFO_DEPTH = 16;
  localparam int MODE_W     = 2;
  // mode field: bit 0 set means least significant bit goes out first
  localparam int MODE_LSB_FIRST_BIT = 0;
  localparam logic [MODE_W-1:0] MODE_RESET = 2'h0;

  // synchronised pin inputs travel together
  typedef struct packed {
    logic              oe;
    logic              sel_n;
    logic              reconf;
    logic [MODE_W-1:0] mode;
  } scbs_pins_t;

  localparam scbs_pins_t PINS_RESET = '{oe: 1'b0, sel_n: 1'b1,
                                        reconf: 1'b0, mode: 2'h0};

  typedef enum logic [1:0] {
    ST_CLEAR,
    ST_ARMED,
    ST_DONE
  } scbs_state_t;

endpackage : scbs_pkg

// *** rtl/scbs_fifo.sv ***
// Purpose: small synchronous FIFO between bitstream memory and shifter
// Assumes: single clock, flush clears contents in one cycle
// Notes:   full and empty come straight from the occupancy count
`timescale 1ns/1ps
`default_nettype none
module scbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX   = AW'(DEPTH - 1);

  logic [WIDTH-1:0] store_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [CW-1:0]    count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != FULL_COUNT);
  assign out_valid = (count_r != '0);
  assign out_data  = store_r[rd_ptr_r];
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_valid && out_ready && !flush;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      store_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == LAST_IDX) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == LAST_IDX) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule : scbs_fifo
`default_nettype wire

// *** tb/scbs_top_asserts.sv ***
// Purpose: port-level assertions for the bitstream source
// Assumes: one sys_clk domain, pins pass a 2-3 cycle synchroniser
// Notes:   repetition counts leave room for synchroniser latency
`timescale 1ns/1ps
`default_nettype none
module scbs_top_asserts (
  input wire logic                        sys_clk,
  input wire logic                        rst,
  input wire logic                        oe_in,
  input wire logic                        oe_out,
  input wire logic                        oe_oe_n,
  input wire logic [scbs_pkg::MODE_W-1:0] mode_in,
  input wire logic                        sel_n_in,
  input wire logic                        dclk_out,
  input wire logic                        target_serial_in,
  input wire logic                        target_serial_in_oe_n,
  input wire logic                        cascade_select_out,
  input wire logic                        reconf_instr,
  input wire logic                        init_conf_out,
  input wire logic                        init_conf_oe_n,
  input wire logic [scbs_pkg::MODE_W-1:0] active_mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_line_up;
    $rose(oe_in) ##0 $stable(mode_in);
  endsequence
  sequence s_settled;
    (oe_in && $stable(mode_in)) [*4];
  endsequence
  a_line_low_float: assert property (
    (!oe_in) [*4] |-> target_serial_in_oe_n && cascade_select_out)
    else $error("data or cascade active while line low");
  a_sel_high_float: assert property (
    sel_n_in [*8] |-> target_serial_in_oe_n && !dclk_out)
    else $error("data or clock active while deselected");
  a_done_float: assert property (
    !cascade_select_out |-> target_serial_in_oe_n)
    else $error("data driven after cascade low");
  a_cascade_holds: assert property (
    (!cascade_select_out && oe_in) [*5] |=> !cascade_select_out)
    else $error("cascade released while line high");
  a_clk_drives: assert property (
    $rose(dclk_out) |-> !target_serial_in_oe_n)
    else $error("serial clock without driven data");
  a_bit_stable: assert property (
    dclk_out && $past(dclk_out) && !target_serial_in_oe_n
      && !$past(target_serial_in_oe_n) |-> $stable(target_serial_in))
    else $error("data moved while serial clock high");
  a_high_phase: assert property (
    $rose(dclk_out) |-> dclk_out [*4] ##1 !dclk_out)
    else $error("serial clock high phase not four cycles");
  a_reconf_pull: assert property (
    $rose(reconf_instr) |-> ##[1:3] (!init_conf_oe_n && !init_conf_out))
    else $error("request not pulled low");
  a_reconf_release: assert property (
    $fell(reconf_instr) |-> ##[1:3] init_conf_oe_n)
    else $error("request not released");
  a_od_low_only: assert property (
    !oe_oe_n |-> !oe_out)
    else $error("enable line driven high");
  a_mode_capture: assert property (
    s_line_up ##1 s_settled |=> active_mode == mode_in)
    else $error("mode not captured on line release");
endmodule : scbs_top_asserts
bind scbs_top scbs_top_asserts u_chk (.sys_clk(sys_clk), .rst(rst),
  .oe_in(oe_in), .oe_out(oe_out), .oe_oe_n(oe_oe_n), .mode_in(mode_in),
  .sel_n_in(sel_n_in), .dclk_out(dclk_out),
  .target_serial_in(target_serial_in),
  .target_serial_in_oe_n(target_serial_in_oe_n),
  .cascade_select_out(cascade_select_out), .reconf_instr(reconf_instr),
  .init_conf_out(init_conf_out), .init_conf_oe_n(init_conf_oe_n),
  .active_mode(active_mode));
`default_nettype wire

// *** tb/scbs_target_model.sv ***
// Purpose: behavioural target device on the serial link
// Assumes: samples data on the rising serial clock
// Notes:   a floated data line reads as the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module scbs_target_model (
  input  wire logic        dclk,
  input  wire logic        data,
  input  wire logic        data_oe_n,
  input  wire logic        hold_low,
  output logic             pull_oe_n,
  output logic      [63:0] bits,
  output int               cnt
);
  logic last;
  logic seen;
  assign pull_oe_n = !hold_low;
  assign seen = data_oe_n ? !last : data;
  // holding the line low restarts the capture
  always @(posedge dclk or posedge hold_low) begin
    if (hold_low) begin
      cnt <= 0;
      bits <= '0;
      last <= 1'b0;
    end else begin
      last <= seen;
      if (cnt < 64) bits[cnt] <= seen;
      cnt <= cnt + 1;
    end
  end
endmodule : scbs_target_model
`default_nettype wire

// *** tb/scbs_top_test.sv ***
// Purpose: self-checking bench of the serial bitstream source
// Assumes: 8 words, 64 stream bits, inputs change on falling edges
// Notes:   the target model captures what crosses the link
`timescale 1ns/1ps
`default_nettype none
module scbs_top_test;
  logic        sys_clk;
  logic        rst;
  logic        prog_we;
  logic [2:0]  prog_addr;
  logic [7:0]  prog_data;
  logic        oe_line;
  logic        oe_out;
  logic        oe_oe_n;
  logic        sel_n_in;
  logic [1:0]  mode_in;
  logic        dclk_out;
  logic        data;
  logic        data_oe_n;
  logic        cascade_select_out;
  logic        reconf_instr;
  logic        init_conf_out;
  logic        init_conf_oe_n;
  logic [1:0]  active_mode;
  logic        hold_low;
  logic        pull_oe_n;
  logic [63:0] bits;
  int          cnt;
  int          num_errors;
  int          n_tests;
  int          k;
  logic [7:0]  mem [8];
  ////////////////////////////////////////////////////////////////////////
  assign oe_line = pull_oe_n & (oe_oe_n | oe_out);
  scbs_top #(.MEM_WORDS(8), .STREAM_BITS(64)) dut (.sys_clk(sys_clk),
    .rst(rst), .prog_we(prog_we), .prog_addr(prog_addr),
    .prog_data(prog_data), .oe_in(oe_line), .oe_out(oe_out),
    .oe_oe_n(oe_oe_n), .sel_n_in(sel_n_in), .mode_in(mode_in),
    .dclk_out(dclk_out), .target_serial_in(data),
    .target_serial_in_oe_n(data_oe_n),
    .cascade_select_out(cascade_select_out), .reconf_instr(reconf_instr),
    .init_conf_out(init_conf_out), .init_conf_oe_n(init_conf_oe_n),
    .active_mode(active_mode));
  scbs_target_model u_tgt (.dclk(dclk_out), .data(data),
    .data_oe_n(data_oe_n), .hold_low(hold_low), .pull_oe_n(pull_oe_n),
    .bits(bits), .cnt(cnt));
  ////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : step
  task automatic check(input string name, input logic [63:0] seen,
                       input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  function automatic logic [63:0] expect_bits(input logic lsb);
    logic [63:0] e;
    for (int i = 0; i < 64; i++) begin
      e[i] = lsb ? mem[i/8][i%8] : mem[i/8][7-i%8];
    end
    return e;
  endfunction : expect_bits
  // new mode is presented before the target lets the line rise
  task automatic start(input logic [1:0] m);
    hold_low = 1'b1;
    sel_n_in = 1'b1;
    mode_in = m;
    step(6);
    hold_low = 1'b0;
    step(8);
  endtask : start
  task automatic finish_stream(input logic lsb);
    for (k = 0; k < 3000 && cascade_select_out !== 1'b0; k++) step(1);
    step(2);
    check("stream", bits, expect_bits(lsb));
    check("count", 64'(cnt), 64'h40);
    check("float", {63'h0, data_oe_n}, 64'h1);
  endtask : finish_stream
  ////////////////////////////////////////////////////////////////////////
  task automatic t_por;
    int n;
    n = 0;
    for (int j = 0; j < 8; j++) begin
      mem[j] = 8'h96 ^ 8'(j * 37);
      prog_we = 1'b1;
      prog_addr = 3'(j);
      prog_data = mem[j];
      step(1);
      n++;
    end
    prog_we = 1'b0;
    while (n < 100 && oe_oe_n === 1'b0) begin
      step(1);
      n++;
    end
    check("por_len", {63'h0, n >= 48 && n <= 51}, 64'h1);
    check("por_float", {63'h0, data_oe_n}, 64'h1);
    $display("t_por finished");
  endtask : t_por
  task automatic t_sel_idle;
    start(2'h2);
    step(40);
    check("idle", {60'h0, dclk_out, data_oe_n, active_mode}, 64'h6);
    check("idle_cnt", 64'(cnt), 64'h0);
    $display("t_sel_idle finished");
  endtask : t_sel_idle
  task automatic t_stall_lsb;
    int n;
    start(2'h1);
    check("mode", {62'h0, active_mode}, 64'h1);
    sel_n_in = 1'b0;
    for (k = 0; k < 1000 && cnt < 20; k++) step(1);
    sel_n_in = 1'b1;
    step(6);
    n = cnt;
    step(40);
    check("stall", {62'h0, dclk_out, data_oe_n}, 64'h1);
    check("held", 64'(cnt), 64'(n));
    sel_n_in = 1'b0;
    finish_stream(1'b1);
    $display("t_stall_lsb finished");
  endtask : t_stall_lsb
  task automatic t_abort;
    start(2'h0);
    sel_n_in = 1'b0;
    for (k = 0; k < 1000 && cnt < 30; k++) step(1);
    hold_low = 1'b1;
    step(6);
    check("abort", {62'h0, data_oe_n, cascade_select_out}, 64'h3);
    hold_low = 1'b0;
    finish_stream(1'b0);
    $display("t_abort finished");
  endtask : t_abort
  task automatic t_reconf;
    reconf_instr = 1'b1;
    step(4);
    check("req", {62'h0, init_conf_oe_n, init_conf_out}, 64'h0);
    reconf_instr = 1'b0;
    step(4);
    check("rel", {63'h0, init_conf_oe_n}, 64'h1);
    $display("t_reconf finished");
  endtask : t_reconf
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    #200000;
    num_errors++;
    $display("[FAIL] watchdog expected finish seen timeout");
    conclude;
  end
  initial begin
    rst = 1'b1;
    prog_we = 1'b0;
    prog_addr = 3'h0;
    prog_data = 8'h00;
    sel_n_in = 1'b1;
    mode_in = 2'h0;
    reconf_instr = 1'b0;
    hold_low = 1'b1;
    num_errors = 0;
    n_tests = 0;
    step(2);
    rst = 1'b0;
    t_por;
    t_sel_idle;
    t_stall_lsb;
    t_abort;
    t_reconf;
    conclude;
  end
endmodule : scbs_top_test
`default_nettype wire
